// [verilog/desc_pkg.sv]
package desc_pkg;

    localparam int unsigned ADDR_W = 6;
    localparam int unsigned REMAIN_W = 7;

    localparam logic [7:0] TYPE_DEVICE = 8'h01;
    localparam logic [7:0] TYPE_CONFIG = 8'h02;
    localparam logic [7:0] TYPE_INTERFACE = 8'h04;
    localparam logic [7:0] TYPE_IAD = 8'h0B;

    localparam logic [7:0] CFG_LEN = 8'h09;
    localparam logic [7:0] IAD_LEN = 8'h08;
    localparam logic [7:0] IF_LEN = 8'h09;
    localparam logic [15:0] TOTAL_LEN = 16'h002C;

    localparam logic [ADDR_W-1:0] CFG_BASE = 6'h00;
    localparam logic [ADDR_W-1:0] IAD_BASE = 6'h09;
    localparam logic [ADDR_W-1:0] IF0_BASE = 6'h11;
    localparam logic [ADDR_W-1:0] IF1A0_BASE = 6'h1A;
    localparam logic [ADDR_W-1:0] IF1A1_BASE = 6'h23;
    localparam logic [ADDR_W-1:0] LAST_ADDR = 6'h2B;

    localparam logic [ADDR_W-1:0] OFS_LEN = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_TYPE = 6'h01;

    localparam logic [ADDR_W-1:0] CFG_OFS_TOTAL_LO = 6'h02;
    localparam logic [ADDR_W-1:0] CFG_OFS_TOTAL_HI = 6'h03;
    localparam logic [ADDR_W-1:0] CFG_OFS_NUM_IF = 6'h04;
    localparam logic [ADDR_W-1:0] CFG_OFS_VALUE = 6'h05;
    localparam logic [ADDR_W-1:0] CFG_OFS_STR = 6'h06;
    localparam logic [ADDR_W-1:0] CFG_OFS_ATTR = 6'h07;
    localparam logic [ADDR_W-1:0] CFG_OFS_MAXPWR = 6'h08;

    localparam logic [ADDR_W-1:0] IAD_OFS_FIRST = 6'h02;
    localparam logic [ADDR_W-1:0] IAD_OFS_COUNT = 6'h03;
    localparam logic [ADDR_W-1:0] IAD_OFS_CLASS = 6'h04;
    localparam logic [ADDR_W-1:0] IAD_OFS_SUB = 6'h05;
    localparam logic [ADDR_W-1:0] IAD_OFS_PROTO = 6'h06;
    localparam logic [ADDR_W-1:0] IAD_OFS_STR = 6'h07;

    localparam logic [ADDR_W-1:0] IF_OFS_NUM = 6'h02;
    localparam logic [ADDR_W-1:0] IF_OFS_ALT = 6'h03;
    localparam logic [ADDR_W-1:0] IF_OFS_NEP = 6'h04;
    localparam logic [ADDR_W-1:0] IF_OFS_CLASS = 6'h05;
    localparam logic [ADDR_W-1:0] IF_OFS_SUB = 6'h06;
    localparam logic [ADDR_W-1:0] IF_OFS_PROTO = 6'h07;
    localparam logic [ADDR_W-1:0] IF_OFS_STR = 6'h08;

    localparam logic [7:0] NUM_INTERFACES = 8'h02;
    localparam logic [7:0] CFG_VALUE = 8'h01;
    localparam logic [7:0] CFG_STR_IDX = 8'h00;
    localparam logic [7:0] FUNC_FIRST_IF = 8'h00;
    localparam logic [7:0] FUNC_IF_COUNT = 8'h02;
    localparam logic [7:0] FUNC_STR_IDX = 8'h04;
    localparam logic [7:0] IF0_NUM = 8'h00;
    localparam logic [7:0] IF1_NUM = 8'h01;
    localparam logic [7:0] ALT_DEFAULT = 8'h00;
    localparam logic [7:0] ALT_SECOND = 8'h01;
    localparam logic [7:0] IF_NUM_EP = 8'h00;
    localparam logic [7:0] IF_CLASS = 8'hFF;
    localparam logic [7:0] IF_SUBCLASS = 8'h01;
    localparam logic [7:0] IF_PROTOCOL = 8'h00;
    localparam logic [7:0] IF_STR_IDX = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    localparam int unsigned ATTR_RSVD_BIT = 7;
    localparam int unsigned ATTR_SELF_BIT = 6;
    localparam int unsigned ATTR_WAKE_BIT = 5;

    localparam int unsigned HS_UNIT_MA = 2;
    localparam int unsigned GENX_UNIT_MA = 8;

    typedef enum logic [1:0] {
        DEV_POWERED = 2'b00,
        DEV_DEFAULT = 2'b01,
        DEV_ADDRESS = 2'b10,
        DEV_CONFIGURED = 2'b11
    } dev_state_e;

    typedef enum logic {
        PH_IDLE = 1'b0,
        PH_STREAM = 1'b1
    } phase_e;

endpackage

// [verilog/desc_rom.sv]
`timescale 1ns/10ps

module desc_rom
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Read port
    input wire logic [desc_pkg::ADDR_W-1:0] rd_addr,
    output logic [7:0] rd_data
);
    import desc_pkg::*;

    typedef struct packed {
        logic [7:0] data;
    } rom_s;

    rom_s st_q;
    rom_s st_d;

    function automatic logic [7:0] if_byte(input logic [ADDR_W-1:0] ofs,
                                           input logic [7:0] num,
                                           input logic [7:0] alt);
        logic [7:0] b;
        b = ZERO_BYTE;
        case (ofs)
            OFS_LEN: b = IF_LEN;
            OFS_TYPE: b = TYPE_INTERFACE;
            IF_OFS_NUM: b = num;
            IF_OFS_ALT: b = alt;
            IF_OFS_NEP: b = IF_NUM_EP;
            IF_OFS_CLASS: b = IF_CLASS;
            IF_OFS_SUB: b = IF_SUBCLASS;
            IF_OFS_PROTO: b = IF_PROTOCOL;
            IF_OFS_STR: b = IF_STR_IDX;
            default: b = ZERO_BYTE;
        endcase
        return b;
    endfunction

    // Attribute and power bytes patched downstream
    function automatic logic [7:0] desc_byte(input logic [ADDR_W-1:0] a);
        logic [7:0] b;
        b = ZERO_BYTE;
        if (a < IAD_BASE)
        begin
            case (a - CFG_BASE)
                OFS_LEN: b = CFG_LEN;
                OFS_TYPE: b = TYPE_CONFIG;
                CFG_OFS_TOTAL_LO: b = TOTAL_LEN[7:0];
                CFG_OFS_TOTAL_HI: b = TOTAL_LEN[15:8];
                CFG_OFS_NUM_IF: b = NUM_INTERFACES;
                CFG_OFS_VALUE: b = CFG_VALUE;
                CFG_OFS_STR: b = CFG_STR_IDX;
                default: b = ZERO_BYTE;
            endcase
        end
        else if (a < IF0_BASE)
        begin
            // Association sits right before the interfaces it groups
            case (a - IAD_BASE)
                OFS_LEN: b = IAD_LEN;
                OFS_TYPE: b = TYPE_IAD;
                IAD_OFS_FIRST: b = FUNC_FIRST_IF;
                IAD_OFS_COUNT: b = FUNC_IF_COUNT;
                IAD_OFS_CLASS: b = IF_CLASS;
                IAD_OFS_SUB: b = IF_SUBCLASS;
                IAD_OFS_PROTO: b = IF_PROTOCOL;
                IAD_OFS_STR: b = FUNC_STR_IDX;
                default: b = ZERO_BYTE;
            endcase
        end
        // Interfaces 0 and 1, every alternate of 1, numbered without gaps
        else if (a < IF1A0_BASE)
            b = if_byte(a - IF0_BASE, IF0_NUM, ALT_DEFAULT);
        else if (a < IF1A1_BASE)
            b = if_byte(a - IF1A0_BASE, IF1_NUM, ALT_DEFAULT);
        else if (a <= LAST_ADDR)
            b = if_byte(a - IF1A1_BASE, IF1_NUM, ALT_SECOND);
        return b;
    endfunction

    always_comb
    begin
        st_d.data = desc_byte(rd_addr);
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign rd_data = st_q.data;

endmodule

// [verilog/assoc_config_source.sv]
`timescale 1ns/10ps

// What this block does
// - Power byte units: 2 mA high speed, 8 mA Gen X.
// - Power byte at configuration offset 8, full-load figure.
// - External supply lost clears self-powered status.
// - Bus power suffices: keep running.
// - Bus power insufficient: back to Powered.
// - Multi-interface function gets an association.
// - Association spans two or more interfaces and all alternates.
// - Association only sent within configuration data.
// - Direct association get or set is refused.
// - Associated interface numbers are contiguous.
// - First interface at association offset 2.
// - Interface count at offset 3.
// - Function class at offset 4, never zero.
// - Function subclass at offset 5.
// - Function protocol at offset 6.
// - Function string index at offset 7.
// - Function codes copy the first interface's codes.
// - Device reports multi-interface class codes.
module assoc_config_source
#(
    parameter int unsigned MAX_POWER_MA = 400,
    parameter bit SELF_POWER_CAP = 1'b1,
    parameter bit REMOTE_WAKE_CAP = 1'b0,
    parameter bit RUN_ON_BUS = 1'b1,
    parameter logic [7:0] MIF_CLASS = 8'hEF,
    parameter logic [7:0] MIF_SUBCLASS = 8'h02,
    parameter logic [7:0] MIF_PROTOCOL = 8'h01
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Descriptor request
    input wire logic req_valid,
    input wire logic req_is_get,
    input wire logic [7:0] req_desc_type,
    input wire logic [15:0] req_length,
    // Descriptor data out
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    output logic req_stall,
    // Link speed and power
    input wire logic gen_x_speed,
    input wire logic ext_power_present,
    // Standard request events
    input wire logic bus_reset,
    input wire logic set_address,
    input wire logic addr_nonzero,
    input wire logic set_config,
    input wire logic [7:0] config_value,
    // Device status
    output logic self_powered,
    output desc_pkg::dev_state_e dev_state,
    output logic [7:0] mif_class,
    output logic [7:0] mif_subclass,
    output logic [7:0] mif_protocol
);
    import desc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        phase_e phase;
        logic [ADDR_W-1:0] addr;
        logic [REMAIN_W-1:0] remain;
        logic issue;
        logic [ADDR_W-1:0] issue_addr;
        logic issue_last;
        logic tx_valid;
        logic [7:0] tx_data;
        logic tx_last;
        logic stall;
        logic ext_prev;
        logic self_powered;
        dev_state_e dev_state;
        logic [7:0] mif_class;
        logic [7:0] mif_subclass;
        logic [7:0] mif_protocol;
    } state_s;

    localparam int unsigned HS_UNITS = (MAX_POWER_MA + HS_UNIT_MA - 1) / HS_UNIT_MA;
    localparam int unsigned GENX_UNITS = (MAX_POWER_MA + GENX_UNIT_MA - 1) / GENX_UNIT_MA;
    localparam logic [7:0] HS_POWER_BYTE = HS_UNITS[7:0];
    localparam logic [7:0] GENX_POWER_BYTE = GENX_UNITS[7:0];
    localparam logic [REMAIN_W-1:0] TOTAL_COUNT = TOTAL_LEN[REMAIN_W-1:0];
    localparam logic [REMAIN_W-1:0] ONE_COUNT = 7'h01;
    localparam logic [ADDR_W-1:0] ONE_ADDR = 6'h01;
    localparam logic [ADDR_W-1:0] CFG_ATTR_ADDR = CFG_BASE + CFG_OFS_ATTR;
    localparam logic [ADDR_W-1:0] CFG_MAXPWR_ADDR = CFG_BASE + CFG_OFS_MAXPWR;
    localparam logic [15:0] ZERO_LEN = 16'h0000;

    state_s st_q;
    state_s st_d;
    logic [7:0] rom_data;

    ////////////////////////////////////////////////////////////////////////////////
    // Request decoding

    function automatic logic is_config_get(input logic is_get, input logic [7:0] dtype);
        return is_get && (dtype == TYPE_CONFIG);
    endfunction

    // Shorter of request and total length
    function automatic logic [REMAIN_W-1:0] clip_len(input logic [15:0] len);
        logic [REMAIN_W-1:0] n;
        n = TOTAL_COUNT;
        if (len < TOTAL_LEN)
            n = len[REMAIN_W-1:0];
        return n;
    endfunction

    // Live fields patched over the stored bytes
    function automatic logic [7:0] patch(input logic [7:0] raw,
                                         input logic [ADDR_W-1:0] a,
                                         input logic genx);
        logic [7:0] b;
        b = raw;
        if (a == CFG_ATTR_ADDR)
        begin
            b = ZERO_BYTE;
            b[ATTR_RSVD_BIT] = 1'b1;
            b[ATTR_SELF_BIT] = SELF_POWER_CAP;
            b[ATTR_WAKE_BIT] = REMOTE_WAKE_CAP;
        end
        else if (a == CFG_MAXPWR_ADDR)
            b = genx ? GENX_POWER_BYTE : HS_POWER_BYTE;
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Descriptor store

    desc_rom u_rom
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .rd_addr(st_q.addr),
        .rd_data(rom_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        st_d = st_q;
        st_d.stall = 1'b0;
        st_d.issue = 1'b0;
        st_d.issue_last = 1'b0;

        // Output stage, one cycle behind the store read
        st_d.tx_valid = st_q.issue;
        st_d.tx_last = st_q.issue && st_q.issue_last;
        st_d.tx_data = st_q.issue ? patch(rom_data, st_q.issue_addr, gen_x_speed) : ZERO_BYTE;

        unique case (st_q.phase)
            PH_IDLE:
            begin
                if (req_valid)
                begin
                    if (is_config_get(req_is_get, req_desc_type) && (req_length != ZERO_LEN))
                    begin
                        // Association only travels inside this stream
                        st_d.phase = PH_STREAM;
                        st_d.addr = CFG_BASE;
                        st_d.remain = clip_len(req_length);
                    end
                    else if (!is_config_get(req_is_get, req_desc_type))
                        st_d.stall = 1'b1;
                end
            end
            PH_STREAM:
            begin
                st_d.issue = 1'b1;
                st_d.issue_addr = st_q.addr;
                st_d.issue_last = (st_q.remain == ONE_COUNT);
                st_d.addr = st_q.addr + ONE_ADDR;
                st_d.remain = st_q.remain - ONE_COUNT;
                if (st_q.remain == ONE_COUNT)
                    st_d.phase = PH_IDLE;
            end
        endcase

        // Self-powered status follows the external supply
        st_d.ext_prev = ext_power_present;
        st_d.self_powered = SELF_POWER_CAP && ext_power_present;

        unique case (st_q.dev_state)
            DEV_POWERED:
            begin
                if (bus_reset)
                    st_d.dev_state = DEV_DEFAULT;
            end
            DEV_DEFAULT:
            begin
                if (set_address && addr_nonzero)
                    st_d.dev_state = DEV_ADDRESS;
            end
            DEV_ADDRESS:
            begin
                if (set_config && (config_value == CFG_VALUE))
                    st_d.dev_state = DEV_CONFIGURED;
                else if (set_address && !addr_nonzero)
                    st_d.dev_state = DEV_DEFAULT;
            end
            DEV_CONFIGURED:
            begin
                if (set_config && (config_value == ZERO_BYTE))
                    st_d.dev_state = DEV_ADDRESS;
            end
        endcase
        if (bus_reset)
            st_d.dev_state = DEV_DEFAULT;

        // Supply lost: carry on if bus power suffices, else back to Powered
        if (st_q.ext_prev && !ext_power_present && SELF_POWER_CAP && !RUN_ON_BUS)
        begin
            st_d.dev_state = DEV_POWERED;
            st_d.phase = PH_IDLE;
        end

        if (bus_reset)
            st_d.phase = PH_IDLE;

        // Device class triple
        st_d.mif_class = MIF_CLASS;
        st_d.mif_subclass = MIF_SUBCLASS;
        st_d.mif_protocol = MIF_PROTOCOL;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    // The one function here spans interfaces 0 and 1, hence one association
    assign tx_valid = st_q.tx_valid;
    assign tx_data = st_q.tx_data;
    assign tx_last = st_q.tx_last;
    assign req_stall = st_q.stall;
    assign self_powered = st_q.self_powered;
    assign dev_state = st_q.dev_state;
    assign mif_class = st_q.mif_class;
    assign mif_subclass = st_q.mif_subclass;
    assign mif_protocol = st_q.mif_protocol;

endmodule

// [tb/assoc_config_chk.sv]
`timescale 1ns/10ps

module assoc_config_chk
import desc_pkg::*;
#(
    parameter bit SELF_POWER_CAP = 1'b1,
    parameter bit RUN_ON_BUS = 1'b1,
    parameter logic [7:0] MIF_CLASS = 8'hEF,
    parameter logic [7:0] MIF_SUBCLASS = 8'h02,
    parameter logic [7:0] MIF_PROTOCOL = 8'h01
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Request and answer
    input wire logic req_valid,
    input wire logic req_is_get,
    input wire logic [7:0] req_desc_type,
    input wire logic [15:0] req_length,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic req_stall,
    // Power and state
    input wire logic ext_power_present,
    input wire logic bus_reset,
    input wire logic set_address,
    input wire logic set_config,
    input wire logic [7:0] config_value,
    input wire logic self_powered,
    input wire desc_pkg::dev_state_e dev_state,
    input wire logic [7:0] mif_class,
    input wire logic [7:0] mif_subclass,
    input wire logic [7:0] mif_protocol
);
    logic busy_q;
    logic take_cfg;

    assign take_cfg = req_valid && !busy_q && req_is_get && req_desc_type == TYPE_CONFIG
        && req_length != 16'h0000;

    // Stream in flight, taking edge to last byte
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            busy_q <= 1'b0;
        else if (tx_last)
            busy_q <= 1'b0;
        else if (take_cfg)
            busy_q <= 1'b1;
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    stall_refuse_a: assert property (
        req_valid && !busy_q && !(req_is_get && req_desc_type == TYPE_CONFIG) |=> req_stall)
        else $error("refused request gave no stall");
    cfg_start_a: assert property (
        take_cfg |=> !req_stall ##2 (tx_valid && tx_data == CFG_LEN))
        else $error("configuration stream did not start in time");
    idle_zero_a: assert property (!tx_valid |-> tx_data == 8'h00)
        else $error("data not zero while idle");
    last_once_a: assert property (tx_last |-> tx_valid ##1 (!tx_valid && !tx_last))
        else $error("last byte marker misplaced");
    self_power_a: assert property (
        !$past(rst) |-> self_powered == (SELF_POWER_CAP && $past(ext_power_present)))
        else $error("self powered status wrong");
    power_loss_a: assert property (
        ext_power_present ##1 (!ext_power_present && !bus_reset && !set_address && !set_config)
        |=> dev_state == ((RUN_ON_BUS || !SELF_POWER_CAP) ? $past(dev_state) : DEV_POWERED))
        else $error("state wrong after power loss");
    bus_reset_a: assert property (
        bus_reset && !($past(ext_power_present) && !ext_power_present) |=> dev_state == DEV_DEFAULT)
        else $error("bus reset did not give default state");
    configure_a: assert property (
        dev_state == DEV_ADDRESS && set_config && config_value == CFG_VALUE && !bus_reset
        && ext_power_present == $past(ext_power_present) |=> dev_state == DEV_CONFIGURED)
        else $error("configuration not entered");
    class_triple_a: assert property (
        !$past(rst) |-> mif_class == MIF_CLASS && mif_subclass == MIF_SUBCLASS
        && mif_protocol == MIF_PROTOCOL)
        else $error("device class triple wrong");
endmodule

bind assoc_config_source assoc_config_chk #(
    .SELF_POWER_CAP(SELF_POWER_CAP), .RUN_ON_BUS(RUN_ON_BUS), .MIF_CLASS(MIF_CLASS),
    .MIF_SUBCLASS(MIF_SUBCLASS), .MIF_PROTOCOL(MIF_PROTOCOL)
) chk (
    .ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req_is_get(req_is_get),
    .req_desc_type(req_desc_type), .req_length(req_length), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .req_stall(req_stall),
    .ext_power_present(ext_power_present), .bus_reset(bus_reset), .set_address(set_address),
    .set_config(set_config), .config_value(config_value), .self_powered(self_powered),
    .dev_state(dev_state), .mif_class(mif_class), .mif_subclass(mif_subclass),
    .mif_protocol(mif_protocol)
);

// [tb/desc_host.sv]
`timescale 1ns/10ps

module desc_host
(
    // Clock
    input wire logic ref_clk,
    // Answer from the device
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic req_stall,
    // Request to the device
    output logic req_valid,
    output logic req_is_get,
    output logic [7:0] req_desc_type,
    output logic [15:0] req_length
);
    logic [7:0] got [0:63];
    int n;
    logic stalled, done;

    initial
    begin
        req_valid = 1'b0;
        req_is_get = 1'b0;
        req_desc_type = 8'h00;
        req_length = 16'h0000;
    end

    // One request, then collect bytes until the last one or a refusal
    task automatic request(input logic get, input logic [7:0] dtype, input logic [15:0] len);
        @(negedge ref_clk);
        req_valid = 1'b1;
        req_is_get = get;
        req_desc_type = dtype;
        req_length = len;
        n = 0;
        stalled = 1'b0;
        done = 1'b0;
        @(negedge ref_clk);
        // Qualifiers are stale once the strobe drops
        req_valid = 1'b0;
        req_is_get = ~get;
        req_desc_type = ~dtype;
        req_length = ~len;
        for (int i = 0; i < 60 && !done; i++)
        begin
            if (req_stall === 1'b1)
                stalled = 1'b1;
            if (tx_valid === 1'b1 && n < 64)
            begin
                got[n] = tx_data;
                n++;
            end
            done = (tx_last === 1'b1) || stalled;
            @(negedge ref_clk);
        end
    endtask
endmodule

// [tb/interface_association_desc_test.sv]
`timescale 1ns/10ps

module interface_association_desc_test;
    import desc_pkg::*;

    localparam int unsigned PWR_MA = 401;

    logic ref_clk, rst, gen_x_speed, ext_power_present, bus_reset, set_address;
    logic addr_nonzero, set_config, req_valid, req_is_get, tx_valid, tx_last;
    logic req_stall, self_powered;
    logic [7:0] config_value, req_desc_type, tx_data, mif_class, mif_subclass, mif_protocol;
    logic [15:0] req_length;
    dev_state_e dev_state, drop_state;
    int mismatches, checks_done;
    logic [7:0] exp_q [0:43];

    desc_host host (.ref_clk(ref_clk), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last), .req_stall(req_stall), .req_valid(req_valid),
        .req_is_get(req_is_get), .req_desc_type(req_desc_type), .req_length(req_length));

    assoc_config_source #(.MAX_POWER_MA(PWR_MA)) uut (.ref_clk(ref_clk), .rst(rst),
        .req_valid(req_valid), .req_is_get(req_is_get), .req_desc_type(req_desc_type),
        .req_length(req_length), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .req_stall(req_stall), .gen_x_speed(gen_x_speed), .ext_power_present(ext_power_present),
        .bus_reset(bus_reset), .set_address(set_address), .addr_nonzero(addr_nonzero),
        .set_config(set_config), .config_value(config_value), .self_powered(self_powered),
        .dev_state(dev_state), .mif_class(mif_class), .mif_subclass(mif_subclass),
        .mif_protocol(mif_protocol));

    // Variant that cannot run on bus power alone
    assoc_config_source #(.MAX_POWER_MA(PWR_MA), .RUN_ON_BUS(1'b0)) uut_drop (.ref_clk(ref_clk),
        .rst(rst), .req_valid(1'b0), .req_is_get(1'b0), .req_desc_type(8'h00),
        .req_length(16'h0000), .tx_valid(), .tx_data(), .tx_last(), .req_stall(),
        .gen_x_speed(gen_x_speed), .ext_power_present(ext_power_present), .bus_reset(bus_reset),
        .set_address(set_address), .addr_nonzero(addr_nonzero), .set_config(set_config),
        .config_value(config_value), .self_powered(), .dev_state(drop_state), .mif_class(),
        .mif_subclass(), .mif_protocol());

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic get(input logic g, input logic [7:0] dtype, input logic [15:0] len);
        host.request(g, dtype, len);
        if (host.done !== 1'b1 && len != 16'h0000)
        begin
            check(8'(host.done), 8'h01);
            end_sim();
        end
    endtask

    task automatic ev(input logic br, input logic sa, input logic nz, input logic sc,
                      input logic [7:0] cv);
        @(negedge ref_clk);
        bus_reset = br;
        set_address = sa;
        addr_nonzero = nz;
        set_config = sc;
        config_value = cv;
        @(negedge ref_clk);
        bus_reset = 1'b0;
        set_address = 1'b0;
        set_config = 1'b0;
        addr_nonzero = ~nz;
        config_value = ~cv;
    endtask

    task automatic build_exp(input logic genx, input logic [7:0] attr);
        logic [7:0] hdr [0:16];
        hdr = '{8'h09, TYPE_CONFIG, 8'h2C, 8'h00, 8'h02, CFG_VALUE, 8'h00, attr, 8'h00,
                8'h08, TYPE_IAD, 8'h00, 8'h02, IF_CLASS, IF_SUBCLASS, IF_PROTOCOL, FUNC_STR_IDX};
        for (int i = 0; i < 17; i++)
            exp_q[i] = hdr[i];
        exp_q[8] = genx ? 8'((PWR_MA + 7) / 8) : 8'((PWR_MA + 1) / 2);
        for (int k = 0; k < 3; k++)
        begin
            hdr = '{8'h09, TYPE_INTERFACE, 8'(k != 0), 8'(k == 2), 8'h00, IF_CLASS, IF_SUBCLASS,
                    IF_PROTOCOL, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
            for (int i = 0; i < 9; i++)
                exp_q[17 + 9 * k + i] = hdr[i];
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        check(8'(dev_state), 8'(DEV_POWERED));
        check(8'(tx_valid), 8'h00);
        repeat (3) @(negedge ref_clk);
        check(mif_class, 8'hEF);
        check(mif_subclass, 8'h02);
        check(mif_protocol, 8'h01);
        check(8'(self_powered), 8'h01);
        $display("reset test done");
    endtask

    task automatic test_full_config();
        build_exp(1'b0, 8'hC0);
        get(1'b1, TYPE_CONFIG, 16'h0064);
        check(8'(host.n), 8'd44);
        for (int i = 0; i < 44; i++)
            check(host.got[i], exp_q[i]);
        check(host.got[11], host.got[19]);
        check(host.got[28], host.got[19] + 8'h01);
        check(8'(host.got[13] == 8'h00), 8'h00);
        check(host.got[13], host.got[22]);
        $display("config test done");
    endtask

    task automatic test_genx_short();
        @(negedge ref_clk);
        gen_x_speed = 1'b1;
        build_exp(1'b1, 8'hC0);
        get(1'b1, TYPE_CONFIG, 16'h0009);
        check(8'(host.n), 8'd9);
        check(host.got[8], exp_q[8]);
        get(1'b1, TYPE_CONFIG, 16'h0001);
        check(8'(host.n), 8'd1);
        check(host.got[0], 8'h09);
        gen_x_speed = 1'b0;
        $display("gen x test done");
    endtask

    task automatic test_refuse();
        logic gets [0:4];
        logic [7:0] types [0:4];
        gets = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
        types = '{TYPE_IAD, TYPE_IAD, TYPE_INTERFACE, TYPE_CONFIG, TYPE_DEVICE};
        for (int i = 0; i < 5; i++)
        begin
            get(gets[i], types[i], 16'h0008);
            check(8'(host.stalled), 8'h01);
            check(8'(host.n), 8'h00);
        end
        get(1'b1, TYPE_CONFIG, 16'h0000);
        check(8'(host.stalled), 8'h00);
        check(8'(host.n), 8'h00);
        $display("refusal test done");
    endtask

    task automatic test_power();
        ev(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
        check(8'(dev_state), 8'(DEV_DEFAULT));
        ev(1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
        check(8'(dev_state), 8'(DEV_ADDRESS));
        ev(1'b0, 1'b0, 1'b0, 1'b1, 8'h01);
        check(8'(dev_state), 8'(DEV_CONFIGURED));
        check(8'(drop_state), 8'(DEV_CONFIGURED));
        @(negedge ref_clk);
        ext_power_present = 1'b0;
        repeat (2) @(negedge ref_clk);
        check(8'(self_powered), 8'h00);
        check(8'(dev_state), 8'(DEV_CONFIGURED));
        check(8'(drop_state), 8'(DEV_POWERED));
        get(1'b1, TYPE_CONFIG, 16'h0009);
        check(8'(host.n), 8'd9);
        check(host.got[7], 8'hC0);
        ext_power_present = 1'b1;
        ev(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
        check(8'(dev_state), 8'(DEV_ADDRESS));
        ev(1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
        check(8'(dev_state), 8'(DEV_DEFAULT));
        $display("power test done");
    endtask

    initial
    begin
        mismatches = 0;
        checks_done = 0;
        rst = 1'b1;
        gen_x_speed = 1'b0;
        ext_power_present = 1'b1;
        bus_reset = 1'b0;
        set_address = 1'b0;
        addr_nonzero = 1'b0;
        set_config = 1'b0;
        config_value = 8'h00;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        test_reset();
        test_full_config();
        test_genx_short();
        test_refuse();
        test_power();
        end_sim();
    end
endmodule
